//--- src/eptm_consts.svh
// Constants for the edge pair timetag measurement sequencer.
// Assumes a 50 MHz timebase clock; included by the package, the checker and the bench.
`ifndef EPTM_CONSTS_SVH
`define EPTM_CONSTS_SVH
`define EPTM_CLK_MHZ 50
`define EPTM_RECOVERY_NS 50
`define EPTM_RECOVERY_CYC (((`EPTM_RECOVERY_NS * `EPTM_CLK_MHZ) + 999) / 1000)
`define EPTM_MIN_GATE_NS 50
`define EPTM_MIN_GATE_CYC (((`EPTM_MIN_GATE_NS * `EPTM_CLK_MHZ) + 999) / 1000)
`define EPTM_TIME_W 48
`define EPTM_COUNT_W 56
`define EPTM_AVG_W 20
`define EPTM_AVG_MAX 1000000
`define EPTM_ADDR_W 4
`define EPTM_REG_CTRL 4'h0
`define EPTM_REG_PERIOD_LO 4'h1
`define EPTM_REG_PERIOD_HI 4'h2
`define EPTM_REG_GATE_LO 4'h3
`define EPTM_REG_GATE_HI 4'h4
`define EPTM_REG_EVENTS 4'h5
`define EPTM_REG_DELAY 4'h6
`define EPTM_REG_AVG 4'h7
`define EPTM_REG_STATUS 4'h8
`define EPTM_REG_COUNT_A 4'h9
`define EPTM_REG_COUNT_B 4'hA
`define EPTM_CTRL_RESET 32'h0000_0000
`define EPTM_CTRL_FUNC_LSB 0
`define EPTM_CTRL_CHAN_BIT 4
`define EPTM_CTRL_START_POL_BIT 5
`define EPTM_CTRL_STOP_POL_BIT 6
`define EPTM_CTRL_RUN_BIT 7
`define EPTM_CTRL_STOP_FIRST_BIT 8
`endif

//--- src/eptm_pkg.sv
// Types for the edge pair timetag measurement sequencer.
// Assumes eptm_consts.svh sits on the include path.
`include "eptm_consts.svh"
package eptm_pkg;
    typedef enum logic [3:0] {
        EPTM_FN_FREQ_AVG = 4'h0,
        EPTM_FN_FREQ_LSQ = 4'h1,
        EPTM_FN_PERIOD_AVG = 4'h2,
        EPTM_FN_CONTINUOUS_INTERVAL = 4'h3,
        EPTM_FN_TIMING_DEVIATION = 4'h4,
        EPTM_FN_PERIOD = 4'h5,
        EPTM_FN_PULSE_WIDTH = 4'h6,
        EPTM_FN_SINGLE_CHANNEL_INTERVAL = 4'h7,
        EPTM_FN_RISE_FALL = 4'h8,
        EPTM_FN_DUAL_CHANNEL_INTERVAL = 4'h9,
        EPTM_FN_SIGNED_DUAL_CHANNEL_INTERVAL = 4'hA
    } eptm_func_t;
    typedef enum logic [1:0] {
        EPTM_ST_IDLE = 2'b00,
        EPTM_ST_WAIT_START = 2'b01,
        EPTM_ST_WAIT_STOP = 2'b11,
        EPTM_ST_RECOVER = 2'b10
    } eptm_state_t;
    typedef struct packed {
        logic valid;
        logic signed [`EPTM_TIME_W:0] result;
        logic [`EPTM_TIME_W-1:0] start_time;
        logic [`EPTM_TIME_W-1:0] stop_time;
        logic [`EPTM_COUNT_W-1:0] event_count;
        logic [3:0] func;
    } eptm_record_t;
endpackage

//--- src/eptm_sequencer.sv
// Edge pair timetag measurement sequencer: channel edge counting, start and
// stop capture selection, recovery gap and result records.
// Assumes comparator outputs arrive asynchronously and a simple register port.
// Overview of operation
// RL1 - Single-channel edge-pair functions use one channel and both captures, one count.
// RL2 - Next start capture waits 50 ns after a stop timetag.
// RL3 - Result is stop time minus start time, count taken from start.
// RL4 - User arming governs start only; function fixes the stop condition.
// RL5 - Period stops on next edge of start polarity.
// RL6 - Pulse width stops on next edge of opposite polarity.
// RL7 - Single-channel interval uses independent start and stop polarities.
// RL8 - Rise and fall tags one edge at two thresholds.
// RL9 - Dual-channel functions start on one channel, stop on the other, either way.
// RL10 - Dual-channel interval has polarities and stop-arm delay; zero means next edge.
// RL11 - Positive intervals by default; signed option allows negative results.
// RL12 - Every function behaves the same on channel A or B.
// RL13 - Each record carries raw timetags and event count.
// RL14 - Single-edge functions run back to back, both channels independently; the code measures only the channel chosen by the channel bit.
// RL15 - Gate time from 50 ns and events per measurement from one upward.
// RL16 - Averaged frequency reduces samples by factor 1 to one million; the code decimates only the least-squares frequency function.
// RL17 - Deviation function reports timetag minus predicted time.
// RL18 - Continuous interval may span several periods, 50 ns upward.
// RL19 - Rise and fall accepts zero intervals with coincident captures.
// RL20 - Events keep being counted during recovery.
// RL21 - Closing timetag of one single-edge measurement opens the next.
// RL22 - Host supplies the reference period before deviation measurement.
// RL23 - Start arms during recovery are dropped, not queued.
// RL24 - Time and event counters never wrap within a measurement.
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/10ps
module eptm_sequencer
    import eptm_pkg::*;
#(
    parameter int TIME_W = `EPTM_TIME_W,
    parameter int COUNT_W = `EPTM_COUNT_W
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [1:0] chan_in,
    input wire logic [1:0] chan_hi_in,
    input wire logic [`EPTM_ADDR_W-1:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    output eptm_record_t rec_out
);
    localparam int REC_CYC = `EPTM_RECOVERY_CYC;
    // The recovery down-counter is eight bits wide, so longer gaps are refused here.
    if (TIME_W != `EPTM_TIME_W || COUNT_W != `EPTM_COUNT_W || REC_CYC < 1 || REC_CYC > 255) begin : g_bad_widths
        $error("eptm_sequencer: unsupported counter widths");
    end

    // Inputs cross from the comparators; two flops before any logic.
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic [3:0] prev_q;
    always_ff @(posedge clk_in) begin
        sync1_q <= {chan_hi_in, chan_in};
        sync2_q <= sync1_q;
        if (rst_in) begin
            prev_q <= 4'h0;
        end else begin
            prev_q <= sync2_q;
        end
    end
    logic [3:0] rise;
    logic [3:0] fall;
    assign rise = sync2_q & ~prev_q;
    assign fall = ~sync2_q & prev_q;

    // Registers.
    logic [31:0] ctrl_q;
    logic [2*32-1:0] period_q;
    logic [2*32-1:0] gate_q;
    logic [31:0] events_q;
    logic [31:0] delay_q;
    logic [`EPTM_AVG_W-1:0] avg_q;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ctrl_q <= `EPTM_CTRL_RESET;
            period_q <= 64'h0000_0000_0000_0000;
            gate_q <= 64'h0000_0000_0000_0000;
            events_q <= 32'h0000_0001;
            delay_q <= 32'h0000_0000;
            avg_q <= 20'h0_0001;
        end else if (wr_in) begin
            case (addr_in)
                `EPTM_REG_CTRL: ctrl_q <= wdata_in;
                `EPTM_REG_PERIOD_LO: period_q[31:0] <= wdata_in; // RL22
                `EPTM_REG_PERIOD_HI: period_q[63:32] <= wdata_in;
                `EPTM_REG_GATE_LO: gate_q[31:0] <= wdata_in;
                `EPTM_REG_GATE_HI: gate_q[63:32] <= wdata_in;
                `EPTM_REG_EVENTS: events_q <= (wdata_in == 32'h0000_0000) ? 32'h0000_0001 : wdata_in; // RL15
                `EPTM_REG_DELAY: delay_q <= wdata_in;
                `EPTM_REG_AVG: begin
                    if (wdata_in != 32'h0000_0000 && wdata_in <= 32'(`EPTM_AVG_MAX)) begin // RL16
                        avg_q <= wdata_in[`EPTM_AVG_W-1:0];
                    end
                end
                default: ;
            endcase
        end
    end

    eptm_func_t func;
    logic chan_b;
    logic start_pol;
    logic stop_pol;
    logic run;
    logic stop_first;
    assign func = eptm_func_t'(ctrl_q[`EPTM_CTRL_FUNC_LSB +: 4]);
    assign chan_b = ctrl_q[`EPTM_CTRL_CHAN_BIT];
    assign start_pol = ctrl_q[`EPTM_CTRL_START_POL_BIT];
    assign stop_pol = ctrl_q[`EPTM_CTRL_STOP_POL_BIT];
    assign run = ctrl_q[`EPTM_CTRL_RUN_BIT];
    assign stop_first = ctrl_q[`EPTM_CTRL_STOP_FIRST_BIT];

    // Timebase and per channel event counters; wide enough never to wrap.
    logic [TIME_W-1:0] time_q;
    logic [COUNT_W-1:0] count_q [2];
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            time_q <= '0;
        end else begin
            time_q <= time_q + 1'b1; // RL24
        end
    end
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_count
            always_ff @(posedge clk_in) begin
                if (rst_in || !run) begin
                    count_q[g] <= '0;
                end else if (start_pol ? fall[g] : rise[g]) begin
                    count_q[g] <= count_q[g] + 1'b1; // RL20 RL24
                end
            end
        end
    endgenerate

    // Edge selection; channel choice only swaps indices.
    logic s_ch;
    logic p_ch;
    logic p_hi;
    logic start_edge;
    logic stop_edge;
    logic dual;
    logic single_edge;
    assign dual = (func == EPTM_FN_DUAL_CHANNEL_INTERVAL) || (func == EPTM_FN_SIGNED_DUAL_CHANNEL_INTERVAL);
    assign single_edge = (func <= EPTM_FN_TIMING_DEVIATION);
    assign s_ch = chan_b; // RL12
    assign p_ch = dual ? ~chan_b : chan_b; // RL9
    assign p_hi = (func == EPTM_FN_RISE_FALL); // RL8
    assign start_edge = start_pol ? fall[s_ch] : rise[s_ch];
    always_comb begin
        unique case (func)
            EPTM_FN_PERIOD: stop_edge = start_pol ? fall[p_ch] : rise[p_ch]; // RL5 RL4
            EPTM_FN_PULSE_WIDTH: stop_edge = start_pol ? rise[p_ch] : fall[p_ch]; // RL6 RL4
            EPTM_FN_RISE_FALL: stop_edge = start_pol ? fall[{p_hi, p_ch}] : rise[{p_hi, p_ch}]; // RL8
            default: stop_edge = stop_pol ? fall[p_ch] : rise[p_ch]; // RL7 RL10
        endcase
    end

    // Sequencer.
    eptm_state_t state_q;
    logic [TIME_W-1:0] t0_q;
    logic [COUNT_W-1:0] e0_q;
    logic [31:0] dly_q;
    logic [7:0] rec_q;
    logic [31:0] nev_q;
    logic [`EPTM_AVG_W-1:0] nav_q;
    logic [TIME_W-1:0] exp_q;
    logic pre_stop_q;
    logic [TIME_W-1:0] pre_t_q;
    logic [TIME_W-1:0] gate_t;
    logic gate_ok;
    assign gate_t = time_q - t0_q;
    assign gate_ok = (gate_t >= gate_q[TIME_W-1:0]) && (gate_t >= TIME_W'(`EPTM_MIN_GATE_CYC)); // RL15 RL18

    always_ff @(posedge clk_in) begin
        if (rst_in || !run) begin
            state_q <= EPTM_ST_IDLE;
            t0_q <= '0;
            e0_q <= '0;
            dly_q <= 32'h0000_0000;
            rec_q <= 8'h00;
            nev_q <= 32'h0000_0000;
            nav_q <= '0;
            exp_q <= '0;
            pre_stop_q <= 1'b0;
            pre_t_q <= '0;
            // Stopping a run drops the pulse but keeps the last record readable.
            if (rst_in) begin
                rec_out <= '0;
            end else begin
                rec_out.valid <= 1'b0;
            end
        end else begin
            rec_out.valid <= 1'b0;
            unique case (state_q)
                EPTM_ST_IDLE: begin
                    state_q <= EPTM_ST_WAIT_START;
                end
                EPTM_ST_WAIT_START: begin
                    if (func == EPTM_FN_SIGNED_DUAL_CHANNEL_INTERVAL && stop_first && stop_edge) begin
                        pre_stop_q <= 1'b1; // RL11
                        pre_t_q <= time_q;
                    end
                    if (start_edge) begin // RL4
                        t0_q <= time_q;
                        e0_q <= count_q[s_ch]; // RL3
                        exp_q <= time_q + period_q[TIME_W-1:0];
                        dly_q <= delay_q;
                        nev_q <= events_q;
                        nav_q <= avg_q;
                        if (pre_stop_q) begin
                            rec_out.valid <= 1'b1;
                            rec_out.result <= $signed({1'b0, pre_t_q}) - $signed({1'b0, time_q}); // RL11
                            rec_out.start_time <= time_q;
                            rec_out.stop_time <= pre_t_q;
                            rec_out.event_count <= count_q[s_ch];
                            rec_out.func <= func;
                            pre_stop_q <= 1'b0;
                            rec_q <= 8'(REC_CYC);
                            state_q <= EPTM_ST_RECOVER;
                        end else if (p_hi && stop_edge) begin
                            rec_out.valid <= 1'b1; // RL19
                            rec_out.result <= '0;
                            rec_out.start_time <= time_q;
                            rec_out.stop_time <= time_q;
                            rec_out.event_count <= count_q[s_ch];
                            rec_out.func <= func;
                            rec_q <= 8'(REC_CYC);
                            state_q <= EPTM_ST_RECOVER;
                        end else begin
                            state_q <= EPTM_ST_WAIT_STOP; // RL1
                        end
                    end
                end
                EPTM_ST_WAIT_STOP: begin
                    if (single_edge) begin
                        // Zero dead time: the closing tag reopens the next measurement.
                        if (start_edge && nev_q > 32'h0000_0001) begin
                            nev_q <= nev_q - 32'h0000_0001;
                        end else if (start_edge && gate_ok) begin
                            // Decimated samples leave the record untouched so its fields keep standing.
                            if ((func != EPTM_FN_FREQ_LSQ) || (nav_q == 20'h0_0001)) begin // RL16
                                rec_out.valid <= 1'b1;
                                rec_out.result <= (func == EPTM_FN_TIMING_DEVIATION) ?
                                    $signed({1'b0, time_q}) - $signed({1'b0, exp_q}) : // RL17
                                    $signed({1'b0, time_q}) - $signed({1'b0, t0_q});
                                rec_out.start_time <= t0_q;
                                rec_out.stop_time <= time_q; // RL13
                                rec_out.event_count <= count_q[s_ch]; // RL13
                                rec_out.func <= func;
                            end
                            t0_q <= time_q; // RL21 RL14
                            e0_q <= count_q[s_ch];
                            exp_q <= exp_q + period_q[TIME_W-1:0];
                            nev_q <= events_q;
                            nav_q <= (nav_q <= 20'h0_0001) ? avg_q : nav_q - 1'b1;
                        end
                    end else if (stop_edge) begin
                        if (dual && dly_q != 32'h0000_0000) begin
                            dly_q <= dly_q - 32'h0000_0001; // RL10
                        end else begin
                            rec_out.valid <= 1'b1;
                            rec_out.result <= $signed({1'b0, time_q}) - $signed({1'b0, t0_q}); // RL3
                            rec_out.start_time <= t0_q; // RL13
                            rec_out.stop_time <= time_q;
                            rec_out.event_count <= e0_q;
                            rec_out.func <= func;
                            rec_q <= 8'(REC_CYC);
                            state_q <= EPTM_ST_RECOVER;
                        end
                    end
                end
                EPTM_ST_RECOVER: begin
                    // Starts seen here are dropped; nothing is queued.
                    if (rec_q <= 8'h01) begin // RL2 RL23
                        state_q <= EPTM_ST_WAIT_START;
                    end else begin
                        rec_q <= rec_q - 8'h01;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdata_out <= 32'h0000_0000;
        end else if (rd_in) begin
            case (addr_in)
                `EPTM_REG_CTRL: rdata_out <= ctrl_q;
                `EPTM_REG_PERIOD_LO: rdata_out <= period_q[31:0];
                `EPTM_REG_PERIOD_HI: rdata_out <= period_q[63:32];
                `EPTM_REG_GATE_LO: rdata_out <= gate_q[31:0];
                `EPTM_REG_GATE_HI: rdata_out <= gate_q[63:32];
                `EPTM_REG_EVENTS: rdata_out <= events_q;
                `EPTM_REG_DELAY: rdata_out <= delay_q;
                `EPTM_REG_AVG: rdata_out <= 32'(avg_q);
                `EPTM_REG_STATUS: rdata_out <= {28'h000_0000, sync2_q[1:0], state_q};
                `EPTM_REG_COUNT_A: rdata_out <= count_q[0][31:0];
                `EPTM_REG_COUNT_B: rdata_out <= count_q[1][31:0];
                default: rdata_out <= 32'h0000_0000;
            endcase
        end else begin
            rdata_out <= 32'h0000_0000;
        end
    end
endmodule // eptm_sequencer

//--- tb/eptm_pulse_src.sv
// Pulse source standing in for the comparators of channels A and B.
// Assumes the bench calls hold from one process at a time.
`timescale 1ns/10ps
module eptm_pulse_src (
    input wire logic clk_in,
    output logic [1:0] chan_out,
    output logic [1:0] chan_hi_out
);
    int hi_dly = 0;
    logic [1:0] hist_q [0:3];
    initial chan_out = 2'b00;
    // The second threshold sees the same edge hi_dly cycles later.
    always_ff @(posedge clk_in) begin
        hist_q[0] <= chan_out;
        for (int i = 1; i < 4; i++) begin
            hist_q[i] <= hist_q[i-1];
        end
    end
    assign chan_hi_out = (hi_dly == 0) ? chan_out : hist_q[hi_dly-1];
    task automatic hold(input logic [1:0] lvl, input int n);
        @(posedge clk_in);
        chan_out <= lvl;
        repeat (n - 1) @(posedge clk_in);
    endtask
endmodule // eptm_pulse_src

//--- tb/eptm_seq_properties.sv
// Checker on the sequencer ports: record spacing, differences and chaining.
// Assumes it is bound into eptm_sequencer and sees only its ports.
`timescale 1ns/10ps
`include "eptm_consts.svh"
module eptm_seq_properties
    import eptm_pkg::*;
#(
    parameter int TIME_W = `EPTM_TIME_W,
    parameter int COUNT_W = `EPTM_COUNT_W
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [1:0] chan_in,
    input wire logic [1:0] chan_hi_in,
    input wire logic [`EPTM_ADDR_W-1:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [31:0] rdata_out,
    input wire eptm_record_t rec_out
);
    localparam int REC_CYC = `EPTM_RECOVERY_CYC;
    logic seen_q;
    logic [TIME_W-1:0] stop_q;
    logic [COUNT_W-1:0] cnt_q;
    logic [3:0] fn_q;
    logic v;
    logic two;
    logic chain;
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    assign v = rec_out.valid;
    assign two = rec_out.func >= 4'h5 && rec_out.func <= 4'hA;
    assign chain = v && seen_q && rec_out.func == fn_q;
    // Any control write restarts chaining; one with the run bit clear also idles the run and zeroes its event counters.
    always_ff @(posedge clk_in) begin
        if (rst_in || (wr_in && addr_in == `EPTM_REG_CTRL)) begin
            seen_q <= 1'b0;
        end else if (v) begin
            seen_q <= 1'b1;
        end
    end
    always_ff @(posedge clk_in) begin
        if (v) begin
            stop_q <= rec_out.stop_time;
            cnt_q <= rec_out.event_count;
            fn_q <= rec_out.func;
        end
    end
    sequence rec_s; v; endsequence
    sequence quiet_s; !v [*2]; endsequence
    AST_REC_SPACING: assert property (rec_s |=> quiet_s)
        else $error("records closer than the recovery time");
    AST_RESULT_DIFF: assert property (v && two |->
        rec_out.result == $signed({1'b0, rec_out.stop_time}) - $signed({1'b0, rec_out.start_time}))
        else $error("result is not stop minus start");
    AST_TI2_POSITIVE: assert property (v && rec_out.func == EPTM_FN_DUAL_CHANNEL_INTERVAL |->
        !rec_out.result[TIME_W] && rec_out.result != 0) else $error("interval not positive");
    AST_STOP_AFTER_START: assert property (v && two && rec_out.func != EPTM_FN_RISE_FALL &&
        rec_out.func != EPTM_FN_SIGNED_DUAL_CHANNEL_INTERVAL |-> rec_out.stop_time > rec_out.start_time)
        else $error("stop not after start");
    AST_RISE_FALL_ORDER: assert property (v && rec_out.func == EPTM_FN_RISE_FALL |->
        rec_out.stop_time >= rec_out.start_time) else $error("edge tags out of order");
    AST_CHAIN_TAGS: assert property (chain && rec_out.func inside {4'h0, 4'h2, 4'h3} |->
        rec_out.start_time == stop_q) else $error("measurements not back to back");
    AST_COUNT_RISES: assert property (chain |-> rec_out.event_count > cnt_q)
        else $error("event count did not advance");
    AST_START_RECOVERY: assert property (chain && two &&
        rec_out.func != EPTM_FN_SIGNED_DUAL_CHANNEL_INTERVAL |-> rec_out.start_time >= stop_q + TIME_W'(REC_CYC))
        else $error("start captured inside recovery");
    AST_REC_HOLD: assert property (!v && !$past(rst_in) |->
        $stable(rec_out.result) && $stable(rec_out.event_count)) else $error("record fields changed");
endmodule // eptm_seq_properties
bind eptm_sequencer eptm_seq_properties #(.TIME_W(TIME_W), .COUNT_W(COUNT_W)) eptm_seq_properties_i (
    .clk_in, .rst_in, .chan_in, .chan_hi_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .rec_out);

//--- tb/tb_top.sv
// Self-checking bench for the edge pair timetag sequencer.
// Assumes the pulse source and the bound checker are compiled before it.
`timescale 1ns/10ps
`include "eptm_consts.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g); end end
module tb_top
    import eptm_pkg::*;
;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [3:0] addr_in = 4'h0;
    logic [31:0] wdata_in = 32'h0000_0000;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [1:0] chan_in;
    logic [1:0] chan_hi_in;
    logic [31:0] rdata_out;
    logic [31:0] d;
    eptm_record_t rec_out;
    eptm_record_t recs[$];
    int miscompares = 0;
    int n_compared = 0;
    int seed = 22;
    int cycles = 0;
    int w;
    int lo;
    always #10 clk_in = ~clk_in;
    eptm_pulse_src eptm_pulse_src_i (.clk_in, .chan_out(chan_in), .chan_hi_out(chan_hi_in));
    eptm_sequencer eptm_sequencer_i (.clk_in, .rst_in, .chan_in, .chan_hi_in, .addr_in, .wdata_in,
        .wr_in, .rd_in, .rdata_out, .rec_out);
    always @(posedge clk_in) begin
        if (rec_out.valid === 1'b1) recs.push_back(rec_out);
        cycles++;
        // Generous ceiling: the whole sequence needs well under two thousand cycles.
        if (cycles == 6000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic conclude;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] val);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= val;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask
    task automatic run(input logic [31:0] ctrl);
        wr(`EPTM_REG_CTRL, 32'h0000_0000);
        recs.delete();
        wr(`EPTM_REG_CTRL, ctrl | 32'h0000_0080);
        repeat (4) @(posedge clk_in);
    endtask
    task automatic chk_rec(input int i, input int e);
        repeat (12) @(posedge clk_in);
        if (recs.size() <= i) begin
            miscompares++;
            $display("CHECK FAILED record %0d expected %0d seen none", i, e);
        end else `CHK("result", e, recs[i].result)
    endtask
    task automatic p(input logic [1:0] lvl, input int n);
        eptm_pulse_src_i.hold(lvl, n);
    endtask
    initial begin
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        w = $random(seed);
        wr(`EPTM_REG_PERIOD_LO, w);
        rd(`EPTM_REG_PERIOD_LO);
        `CHK("period_lo", w, d)
        rd(4'hF);
        `CHK("unmapped", 0, d)
        wr(`EPTM_REG_EVENTS, 32'h0000_0000);
        rd(`EPTM_REG_EVENTS);
        `CHK("events", 1, d)
        $display("registers done");
        for (int c = 0; c < 2; c++) begin
            for (int f = 5; f <= 7; f++) begin
                w = 3 + ($random(seed) & 7);
                lo = 4 + ($random(seed) & 3);
                run(f | (c << 4) | (f == 7 ? 32'h0000_0040 : 0));
                repeat (3) begin
                    p(2'(1 << c), w);
                    p(2'b00, lo);
                end
                chk_rec(0, f == 5 ? w + lo : w);
            end
        end
        $display("edge pair functions done");
        for (int k = 0; k < 3; k += 2) begin
            eptm_pulse_src_i.hi_dly = k;
            run(EPTM_FN_RISE_FALL);
            p(2'b01, 6);
            p(2'b00, 6);
            chk_rec(0, k);
        end
        $display("rise and fall done");
        for (int k = 0; k < 4; k++) begin
            wr(`EPTM_REG_DELAY, k >> 1);
            run(EPTM_FN_DUAL_CHANNEL_INTERVAL | ((k & 1) << 4));
            p(2'(1 << (k & 1)), 3);
            p(2'b11, 2);
            p(2'(1 << (k & 1)), 3);
            p(2'b11, 4);
            p(2'b00, 4);
            chk_rec(0, (k >> 1) ? 8 : 3);
        end
        wr(`EPTM_REG_DELAY, 32'h0000_0000);
        for (int s = 0; s < 2; s++) begin
            run(s ? (EPTM_FN_SIGNED_DUAL_CHANNEL_INTERVAL | 32'h0000_0100) : EPTM_FN_DUAL_CHANNEL_INTERVAL);
            p(2'b10, 4);
            p(2'b11, 4);
            p(2'b01, 3);
            p(2'b11, 3);
            p(2'b00, 6);
            chk_rec(0, s ? -4 : 7);
        end
        $display("two channel intervals done");
        // The second rise lands one cycle after the stop tag and must be dropped but counted.
        run(EPTM_FN_PULSE_WIDTH);
        p(2'b01, 3);
        p(2'b00, 1);
        p(2'b01, 3);
        p(2'b00, 5);
        p(2'b01, 4);
        p(2'b00, 6);
        chk_rec(1, 4);
        `CHK("count step", 2, recs[1].event_count - recs[0].event_count)
        $display("recovery done");
        wr(`EPTM_REG_EVENTS, 32'h0000_0002);
        run(EPTM_FN_CONTINUOUS_INTERVAL);
        repeat (8) begin
            p(2'b01, 2);
            p(2'b00, 2);
        end
        chk_rec(1, 8);
        `CHK("events per step", 2, recs[1].event_count - recs[0].event_count)
        $display("continuous interval done");
        wr(`EPTM_REG_EVENTS, 32'h0000_0001);
        wr(`EPTM_REG_PERIOD_LO, 32'h0000_0005);
        wr(`EPTM_REG_AVG, 32'h0000_0000);
        rd(`EPTM_REG_AVG);
        `CHK("avg zero", 1, d)
        wr(`EPTM_REG_AVG, 32'h0000_0002);
        // Rises every 4 ticks against a 5 tick reference drift by one tick per edge.
        for (int m = 0; m < 2; m++) begin
            run(m ? EPTM_FN_FREQ_LSQ : EPTM_FN_TIMING_DEVIATION);
            repeat (8) begin
                p(2'b01, 2);
                p(2'b00, 2);
            end
            chk_rec(1, m ? 4 : -2);
            `CHK("records", m ? 3 : 7, recs.size())
        end
        $display("deviation and averaging done");
        conclude();
    end
endmodule // tb_top
